// >>> core/epc_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  one-time-programmable memory write control. Included by the design
  modules, not by the package; holds definitions only.
*/
`ifndef EPC_MAP_SVH
`define EPC_MAP_SVH

`define EPC_OFF_CTRL     4'h0
`define EPC_OFF_STATUS   4'h1
`define EPC_OFF_LAMP     4'h2
`define EPC_OFF_ADDR_LO  4'h3
`define EPC_OFF_ADDR_HI  4'h4
`define EPC_OFF_DATA     4'h5

`define EPC_CTRL_BURN    0
`define EPC_CTRL_HOLD    2
`define EPC_LAMP_WRITE   0
`define EPC_LAMP_CHECK   1

`define EPC_CTRL_RESET   8'h00
`define EPC_LAMP_RESET   2'h0

`define EPC_ROM_LO       16'h3F00
`define EPC_ROM_HI       16'h3FEF
`define EPC_ARRAY_LO     16'h0020
`define EPC_ARRAY_HI     16'h3EFF

`define EPC_SYNC_STAGES  2
`define EPC_STRAP_WAIT   2'h3

`endif

// >>> core/epc_pkg.sv
/*
  Types of the programmable memory write control: boot functions and the
  packed state record of the top module. Assumes epc_map.svh on the path.
*/
package epc_pkg;

  typedef enum logic [2:0] {
    EPC_FN_WRITE_CHECK,
    EPC_FN_CHECK_ONLY,
    EPC_FN_LOAD_RAM,
    EPC_FN_SECURE,
    EPC_FN_NONE
  } epc_func_t;

  typedef struct packed {
    logic [1:0]  strap_cnt;
    logic        strap_done;
    logic        boot;
    epc_func_t   func;
    logic        hold;
    logic        burn;
    logic        latched;
    logic [15:0] nvm_addr;
    logic [7:0]  nvm_data;
    logic        nvm_rd;
    logic [7:0]  mem_rdata;
    logic [7:0]  reg_rdata;
    logic [1:0]  lamps_sw;
    logic        write_lamp;
    logic        check_lamp;
    logic        vpp;
    logic        rom_sel;
  } epc_state_t;

endpackage

// >>> core/epc_sync.sv
/*
  Two-stage synchroniser for a group of pin levels. Assumes the pins are
  quasi-static; no bit-to-bit coherence is promised across the group.
*/
`timescale 1ns/1ns
`include "epc_map.svh"
module epc_sync import epc_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         mclk,   // processor clock
  input  wire logic         arst_n, // async reset, active low
  input  wire logic [W-1:0] d,      // raw pin levels
  output logic      [W-1:0] q       // synchronised levels
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      // first stage read only by the second
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate
endmodule

// >>> core/epc_func_decode.sv
/*
  Decoder of the three boot function select levels, high pin first.
  Assumes synchronised inputs.
*/
`timescale 1ns/1ns
`include "epc_map.svh"
module epc_func_decode import epc_pkg::*; (
  input  wire logic [2:0] sel,  // {hi, mid, lo} select levels
  output epc_func_t       func  // decoded boot function
);
  always_comb begin
    if (sel[2]) begin
      func = EPC_FN_SECURE;
    end else begin
      case (sel[1:0])
        2'h0:    func = EPC_FN_WRITE_CHECK;
        2'h1:    func = EPC_FN_CHECK_ONLY;
        2'h2:    func = EPC_FN_LOAD_RAM;
        default: func = EPC_FN_NONE;
      endcase
    end
  end
endmodule

// >>> core/eprom_program_control.sv
/*
  Programmable memory write control: boot mode strap at reset release,
  boot function decode, indicator lamps, and the one-byte write control
  register that captures address and data and gates programming voltage.
  Assumes the processor memory port and register port run on mclk, and
  that the array answers array_rdata in the same cycle as nvm_rd_q.
*/
`timescale 1ns/1ns
`include "epc_map.svh"
module eprom_program_control import epc_pkg::*; (
  input  wire logic        mclk,                // processor clock, 100 MHz
  input  wire logic        arst_n,              // chip reset, active low
  input  wire logic [3:0]  reg_addr,            // register offset
  input  wire logic [7:0]  reg_wdata,           // register write data
  input  wire logic        reg_wr,              // register write strobe
  input  wire logic        reg_rd,              // register read strobe
  output logic      [7:0]  reg_rdata_q,         // read data, cycle after strobe
  input  wire logic [15:0] cpu_addr,            // processor memory address
  input  wire logic [7:0]  cpu_wdata,           // processor write data
  input  wire logic        cpu_wr,              // processor memory write
  input  wire logic        cpu_rd,              // processor memory read
  output logic      [7:0]  cpu_rdata_q,         // array read data to processor
  input  wire logic [7:0]  array_rdata,         // array read data
  output logic      [15:0] nvm_addr_q,          // address to array
  output logic      [7:0]  nvm_data_q,          // held data to array
  output logic             nvm_rd_q,            // array read enable
  output logic             program_voltage_q,   // programming voltage on
  output logic             boot_mode_q,         // boot mode entered
  output logic             boot_rom_sel_q,      // boot rom selected
  input  wire logic        test_level_voltage,  // interrupt pin at test level
  input  wire logic        timer_capture_pin,   // capture pin level
  input  wire logic        function_select_hi,  // boot select, high
  input  wire logic        function_select_mid, // boot select, middle
  input  wire logic        function_select_lo,  // boot select, low
  output logic             write_lamp_pin,      // write indicator lamp
  output logic             check_lamp_pin       // check indicator lamp
);

  epc_state_t st_q;
  epc_state_t st_d;
  logic [4:0] pins_s;
  epc_func_t  func_dec;

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  epc_sync #(
    .W (5)
  ) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      ({test_level_voltage, timer_capture_pin, function_select_hi,
              function_select_mid, function_select_lo}),
    .q      (pins_s)
  );

  epc_func_decode u_dec (
    .sel  (pins_s[2:0]),
    .func (func_dec)
  );

  logic ctrl_wr;
  logic lamp_wr;
  logic arr_wr;
  logic arr_rd;
  logic rom_hit;

  assign ctrl_wr = reg_wr && (reg_addr == `EPC_OFF_CTRL);
  assign lamp_wr = reg_wr && (reg_addr == `EPC_OFF_LAMP);
  assign arr_wr  = cpu_wr && in_range(cpu_addr, `EPC_ARRAY_LO, `EPC_ARRAY_HI);
  assign arr_rd  = cpu_rd && in_range(cpu_addr, `EPC_ARRAY_LO, `EPC_ARRAY_HI);
  assign rom_hit = in_range(cpu_addr, `EPC_ROM_LO, `EPC_ROM_HI);

  always_comb begin
    st_d = st_q;

    // straps are read only after the synchroniser has filled
    if (!st_q.strap_done) begin
      if (st_q.strap_cnt == `EPC_STRAP_WAIT) begin
        st_d.strap_done = 1'b1;
        st_d.boot = pins_s[4] && pins_s[3];
      end else begin
        st_d.strap_cnt = st_q.strap_cnt + 2'h1;
      end
    end

    // function follows select pins in boot mode
    st_d.func = st_q.boot ? func_dec : EPC_FN_NONE;

    // boot rom fetches only in boot mode
    st_d.rom_sel = st_q.boot && cpu_rd && rom_hit;

    if (ctrl_wr) begin
      st_d.hold = reg_wdata[`EPC_CTRL_HOLD];
      // hold and burn never rise together
      st_d.burn = reg_wdata[`EPC_CTRL_BURN] && st_q.hold &&
                  reg_wdata[`EPC_CTRL_HOLD];
      if (!reg_wdata[`EPC_CTRL_HOLD]) begin
        st_d.latched = 1'b0;
      end
    end

    // capture the first array write while holding
    // this is how the boot routine copies each image byte
    if (st_q.hold && !st_q.latched && arr_wr) begin
      st_d.latched  = 1'b1;
      st_d.nvm_addr = cpu_addr;
      st_d.nvm_data = cpu_wdata;
    end else if (!st_q.hold) begin
      st_d.nvm_addr = cpu_addr;
    end

    st_d.nvm_rd    = arr_rd && !st_q.hold;
    st_d.mem_rdata = st_q.nvm_rd ? array_rdata : 8'h00;

    st_d.vpp = st_d.burn;

    if (lamp_wr) begin
      st_d.lamps_sw = reg_wdata[1:0];
    end
    st_d.write_lamp = st_q.boot && st_q.lamps_sw[`EPC_LAMP_WRITE];
    st_d.check_lamp = st_q.boot && st_q.lamps_sw[`EPC_LAMP_CHECK];

    st_d.reg_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `EPC_OFF_CTRL:    st_d.reg_rdata = {5'h00, st_q.hold, 1'b0, st_q.burn};
        `EPC_OFF_STATUS:  st_d.reg_rdata = {2'h0, st_q.latched, pins_s[2:0],
                                            st_q.strap_done, st_q.boot};
        `EPC_OFF_LAMP:    st_d.reg_rdata = {6'h00, st_q.lamps_sw};
        `EPC_OFF_ADDR_LO: st_d.reg_rdata = st_q.nvm_addr[7:0];
        `EPC_OFF_ADDR_HI: st_d.reg_rdata = st_q.nvm_addr[15:8];
        `EPC_OFF_DATA:    st_d.reg_rdata = st_q.nvm_data;
        default:          st_d.reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q            <= '0;
      st_q.func       <= EPC_FN_NONE;
      st_q.hold       <= 1'((`EPC_CTRL_RESET >> `EPC_CTRL_HOLD) & 8'h01);
      st_q.lamps_sw   <= `EPC_LAMP_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_q       = st_q.reg_rdata;
  assign cpu_rdata_q       = st_q.mem_rdata;
  assign nvm_addr_q        = st_q.nvm_addr;
  assign nvm_data_q        = st_q.nvm_data;
  assign nvm_rd_q          = st_q.nvm_rd;
  assign program_voltage_q = st_q.vpp;
  assign boot_mode_q       = st_q.boot;
  assign boot_rom_sel_q    = st_q.rom_sel;
  assign write_lamp_pin    = st_q.write_lamp;
  assign check_lamp_pin    = st_q.check_lamp;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  property p_burn_needs_hold;
    st_q.burn |-> st_q.hold;
  endproperty
  a_burn_needs_hold: assert property (p_burn_needs_hold)
    else $error("burn set without hold");

  property p_no_joint_set;
    ctrl_wr && !st_q.hold |=> !st_q.burn && st_q.hold == $past(reg_wdata[`EPC_CTRL_HOLD]);
  endproperty
  a_no_joint_set: assert property (p_no_joint_set)
    else $error("hold and burn rose in one write");

  property p_read_blocked;
    st_q.hold && cpu_rd |=> !st_q.nvm_rd ##1 cpu_rdata_q == 8'h00;
  endproperty
  a_read_blocked: assert property (p_read_blocked)
    else $error("array read while holding");

  property p_read_normal;
    !st_q.hold && arr_rd |=> st_q.nvm_rd && nvm_addr_q == $past(cpu_addr);
  endproperty
  a_read_normal: assert property (p_read_normal)
    else $error("ordinary read path broken");

  property p_capture;
    st_q.hold && !st_q.latched && arr_wr && !ctrl_wr
      |=> st_q.latched && nvm_addr_q == $past(cpu_addr) && nvm_data_q == $past(cpu_wdata);
  endproperty
  a_capture: assert property (p_capture)
    else $error("array write not captured");

  property p_capture_held;
    st_q.latched && st_q.hold && !ctrl_wr |=> $stable(nvm_addr_q) && $stable(nvm_data_q);
  endproperty
  a_capture_held: assert property (p_capture_held)
    else $error("captured address or data moved");

  property p_voltage;
    ctrl_wr && st_q.hold && reg_wdata[`EPC_CTRL_HOLD] |=>
      program_voltage_q == $past(reg_wdata[`EPC_CTRL_BURN]);
  endproperty
  a_voltage: assert property (p_voltage)
    else $error("programming voltage does not follow burn");

  property p_strap;
    !st_q.strap_done && st_q.strap_cnt == `EPC_STRAP_WAIT
      |=> boot_mode_q == ($past(pins_s[4]) && $past(pins_s[3])) ##1 $stable(boot_mode_q);
  endproperty
  a_strap: assert property (p_strap)
    else $error("boot mode strap wrong");

  property p_secure;
    st_q.boot && pins_s[2] |=> st_q.func == EPC_FN_SECURE;
  endproperty
  a_secure: assert property (p_secure)
    else $error("secure function not decoded");

  property p_lamps_off;
    !st_q.boot && $past(!st_q.boot) |-> !write_lamp_pin && !check_lamp_pin;
  endproperty
  a_lamps_off: assert property (p_lamps_off)
    else $error("lamp driven outside boot mode");

  property p_rom_sel;
    boot_rom_sel_q |-> $past(st_q.boot) && $past(cpu_rd) &&
      $past(cpu_addr) >= `EPC_ROM_LO && $past(cpu_addr) <= `EPC_ROM_HI;
  endproperty
  a_rom_sel: assert property (p_rom_sel)
    else $error("boot rom selected out of range");

  property p_rom_user;
    !st_q.boot |=> !boot_rom_sel_q;
  endproperty
  a_rom_user: assert property (p_rom_user)
    else $error("boot rom selected in user mode");

  property p_boot_fixed;
    st_q.strap_done |=> $stable(boot_mode_q);
  endproperty
  a_boot_fixed: assert property (p_boot_fixed)
    else $error("boot mode moved after strap");

  property p_func_user;
    !st_q.boot |=> st_q.func == EPC_FN_NONE;
  endproperty
  a_func_user: assert property (p_func_user)
    else $error("boot function decoded in user mode");

  property p_func_write_check;
    st_q.boot && pins_s[2:0] == 3'h0 |=> st_q.func == EPC_FN_WRITE_CHECK;
  endproperty
  a_func_write_check: assert property (p_func_write_check)
    else $error("write and check function not decoded");

  property p_func_check_only;
    st_q.boot && pins_s[2:0] == 3'h1 |=> st_q.func == EPC_FN_CHECK_ONLY;
  endproperty
  a_func_check_only: assert property (p_func_check_only)
    else $error("check only function not decoded");

  property p_func_load_ram;
    st_q.boot && pins_s[2:0] == 3'h2 |=> st_q.func == EPC_FN_LOAD_RAM;
  endproperty
  a_func_load_ram: assert property (p_func_load_ram)
    else $error("load ram function not decoded");

  property p_burn_off;
    ctrl_wr && !reg_wdata[`EPC_CTRL_BURN] |=> !program_voltage_q;
  endproperty
  a_burn_off: assert property (p_burn_off)
    else $error("programming voltage stayed on after clear");

  property p_burn_refused;
    ctrl_wr && !st_q.hold |=> !program_voltage_q;
  endproperty
  a_burn_refused: assert property (p_burn_refused)
    else $error("programming voltage on without earlier hold");

  property p_ctrl_readback;
    reg_rd && reg_addr == `EPC_OFF_CTRL |=> reg_rdata_q[`EPC_CTRL_HOLD] == $past(st_q.hold) &&
      reg_rdata_q[`EPC_CTRL_BURN] == $past(st_q.burn);
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("control bits do not read back");

  property p_read_data;
    st_q.nvm_rd |=> cpu_rdata_q == $past(array_rdata);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("array data not passed to processor");

  property p_read_idle;
    !st_q.nvm_rd |=> cpu_rdata_q == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("processor read data without array read");

  property p_lamp_write;
    st_q.boot && st_q.lamps_sw[`EPC_LAMP_WRITE] |=> write_lamp_pin;
  endproperty
  a_lamp_write: assert property (p_lamp_write)
    else $error("write lamp not driven in boot mode");

  property p_lamp_check;
    st_q.boot && st_q.lamps_sw[`EPC_LAMP_CHECK] |=> check_lamp_pin;
  endproperty
  a_lamp_check: assert property (p_lamp_check)
    else $error("check lamp not driven in boot mode");

endmodule

// >>> dv/epc_array_model.sv
/*
  Behavioural programmable array on the far side of the write control.
  Assumes address, data, read enable and voltage all move on mclk.
*/
`timescale 1ns/1ns
module epc_array_model (
  input  wire logic        mclk,              // processor clock
  input  wire logic [15:0] nvm_addr_q,        // array address
  input  wire logic [7:0]  nvm_data_q,        // held write data
  input  wire logic        nvm_rd_q,          // read enable
  input  wire logic        program_voltage_q, // programming voltage on
  output logic      [7:0]  array_rdata        // read data
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  initial begin
    // erased cells read all ones
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hFF;
    end
  end
  // one cell per address
  // idle bus shows the inverse of its previous cycle, so it toggles and a stale byte returns every second idle cycle
  assign array_rdata = nvm_rd_q ? mem[nvm_addr_q] : ~last_q;
  always @(posedge mclk) begin
    last_q <= array_rdata;
    if (program_voltage_q) begin
      mem[nvm_addr_q] <= mem[nvm_addr_q] & nvm_data_q;
    end
  end
endmodule

// >>> dv/test_eprom_program_control.sv
/*
  Self-checking bench of the programmable memory write control.
  Assumes the array model beside the design and a 100 MHz mclk.
*/
`timescale 1ns/1ns
module test_eprom_program_control;
  logic        mclk, arst_n, reg_wr, reg_rd, cpu_wr, cpu_rd, nvm_rd_q, program_voltage_q;
  logic        boot_mode_q, boot_rom_sel_q, test_level_voltage, timer_capture_pin;
  logic        function_select_hi, function_select_mid, function_select_lo, write_lamp_pin, check_lamp_pin;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata_q, cpu_wdata, cpu_rdata_q, array_rdata, nvm_data_q;
  logic [15:0] cpu_addr, nvm_addr_q;
  int          n_mismatch, n_checks;
  logic [19:0] rows [10];
  logic [15:0] roms [4];
  logic [4:0]  straps [7];

  eprom_program_control eprom_program_control_i (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata_q(cpu_rdata_q), .array_rdata(array_rdata),
    .nvm_addr_q(nvm_addr_q), .nvm_data_q(nvm_data_q), .nvm_rd_q(nvm_rd_q),
    .program_voltage_q(program_voltage_q), .boot_mode_q(boot_mode_q), .boot_rom_sel_q(boot_rom_sel_q),
    .test_level_voltage(test_level_voltage), .timer_capture_pin(timer_capture_pin),
    .function_select_hi(function_select_hi), .function_select_mid(function_select_mid),
    .function_select_lo(function_select_lo), .write_lamp_pin(write_lamp_pin), .check_lamp_pin(check_lamp_pin)
  );

  epc_array_model epc_array_model_i (
    .mclk(mclk), .nvm_addr_q(nvm_addr_q), .nvm_data_q(nvm_data_q), .nvm_rd_q(nvm_rd_q),
    .program_voltage_q(program_voltage_q), .array_rdata(array_rdata)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic end_of_test;
    $display("mismatches %0d, checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata_q}, {8'h00, e});
  endtask

  task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_wr    <= w;
    cpu_rd    <= ~w;
    @(posedge mclk);
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
    #1;
  endtask

  // pins held steady well past the strap sample
  task automatic strap(input logic [4:0] s);
    arst_n <= 1'b0;
    {test_level_voltage, timer_capture_pin, function_select_hi, function_select_mid, function_select_lo} <= s;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
  endtask

  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    end_of_test;
  end

  initial begin
    arst_n = 1'b0;
    {reg_wr, reg_rd, cpu_wr, cpu_rd} = 4'h0;
    {reg_addr, reg_wdata, cpu_addr, cpu_wdata} = 36'h000000000;
    {test_level_voltage, timer_capture_pin, function_select_hi, function_select_mid, function_select_lo} = 5'h18;
    n_mismatch = 0;
    n_checks = 0;
    straps = '{5'h18, 5'h19, 5'h1A, 5'h1C, 5'h1F, 5'h08, 5'h10};
    // control writes keep reserved bits zero
    rows = '{20'h00404, 20'h00505, 20'h00404, 20'h00000, 20'h00504,
             20'h00100, 20'h20303, 20'h20000, 20'h9FF00, 20'h1FF03};
    roms = '{16'h3F00, 16'h3FEF, 16'h3FF0, 16'h3EFF};
    foreach (straps[i]) begin
      strap(straps[i]);
      chk({15'h0000, boot_mode_q}, {15'h0000, straps[i][4] & straps[i][3]});
      rd(4'h1, {3'h0, straps[i][2:0], 1'b1, straps[i][4] & straps[i][3]});
    end
    // lamps stay dark in user mode
    wr(4'h2, 8'h03);
    repeat (2) @(posedge mclk);
    #1;
    chk({14'h0000, write_lamp_pin, check_lamp_pin}, 16'h0000);
    strap(5'h18);
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16], rows[i][7:0]);
    end
    wr(4'h2, 8'h01);
    @(posedge mclk);
    #1;
    chk({14'h0000, write_lamp_pin, check_lamp_pin}, 16'h0002);
    wr(4'h2, 8'h02);
    @(posedge mclk);
    #1;
    chk({14'h0000, write_lamp_pin, check_lamp_pin}, 16'h0001);
    wr(4'h0, 8'h04);
    cpu(1'b1, 16'h0100, 8'hA5);
    chk(nvm_addr_q, 16'h0100);
    cpu(1'b1, 16'h0200, 8'h3C);
    chk(nvm_addr_q, 16'h0100);
    chk({8'h00, nvm_data_q}, 16'h00A5);
    cpu(1'b0, 16'h0100, 8'h00);
    chk({15'h0000, nvm_rd_q}, 16'h0000);
    @(posedge mclk);
    #1;
    chk({8'h00, cpu_rdata_q}, 16'h0000);
    rd(4'h1, 8'h23);
    wr(4'h0, 8'h05);
    chk({15'h0000, program_voltage_q}, 16'h0001);
    repeat (3) @(posedge mclk);
    wr(4'h0, 8'h04);
    chk({15'h0000, program_voltage_q}, 16'h0000);
    wr(4'h0, 8'h00);
    cpu(1'b0, 16'h0100, 8'h00);
    chk({15'h0000, nvm_rd_q}, 16'h0001);
    chk(nvm_addr_q, 16'h0100);
    @(posedge mclk);
    #1;
    chk({8'h00, cpu_rdata_q}, 16'h00A5);
    foreach (roms[i]) begin
      cpu(1'b0, roms[i], 8'h00);
      chk({15'h0000, boot_rom_sel_q}, {15'h0000, roms[i] >= 16'h3F00 && roms[i] <= 16'h3FEF});
    end
    end_of_test;
  end
endmodule
